/* logic/sfr_pkg.sv */
// shared constants and types for the bank 3 special-function register map
// assumes an 8-bit core data path and a 9-bit data-memory address
package sfr_pkg;

  // ==========================================================================
  // widths
  localparam int DATA_W = 8;
  localparam int ADDR_W = 9;
  localparam int NBANK  = 4;
  localparam int PCH_W  = 5;

  // ==========================================================================
  // register offsets
  localparam logic [ADDR_W-1:0] OFS_INDIRECT_PORT = 9'h180;
  localparam logic [ADDR_W-1:0] OFS_OPTION        = 9'h181;
  localparam logic [ADDR_W-1:0] OFS_PC_LOW        = 9'h182;
  localparam logic [ADDR_W-1:0] OFS_STATUS        = 9'h183;
  localparam logic [ADDR_W-1:0] OFS_IND_POINTER   = 9'h184;
  localparam logic [ADDR_W-1:0] OFS_PORTB_DIR     = 9'h186;
  localparam logic [ADDR_W-1:0] OFS_PCH_LATCH     = 9'h18a;
  localparam logic [ADDR_W-1:0] OFS_INT_CONTROL   = 9'h18b;

  // ==========================================================================
  // status field positions
  localparam int BIT_IND_BANK = 7;
  localparam int BIT_BANK_HI  = 6;
  localparam int BIT_BANK_LO  = 5;
  localparam int BIT_WDT_EXP  = 4;
  localparam int BIT_SLEEP    = 3;
  localparam int BIT_ZERO     = 2;
  localparam int BIT_NIBBLE   = 1;
  localparam int BIT_CARRY    = 0;
  // index into the three-bit alu flag group
  localparam int FLG_ZERO     = 2;
  localparam int FLG_NIBBLE   = 1;
  localparam int FLG_CARRY    = 0;

  // ==========================================================================
  // reset values
  localparam logic [DATA_W-1:0] RST_OPTION    = 8'hff;
  localparam logic [DATA_W-1:0] RST_PC_LOW    = 8'h00;
  localparam logic [DATA_W-1:0] RST_PORTB_DIR = 8'hff;
  localparam logic [PCH_W-1:0]  RST_PCH_LATCH = 5'h00;
  localparam logic [DATA_W-1:0] RST_INT_CTRL  = 8'h00;
  localparam logic [DATA_W-1:0] RST_POINTER   = 8'h00;
  localparam logic [2:0]        RST_BANK_SEL  = 3'h0;
  localparam logic [2:0]        RST_ALU_FLAGS = 3'h0;
  localparam logic [2:0]        CLR_BANK_SEL  = 3'h0;
  localparam logic [DATA_W-1:0] ZERO_BYTE     = 8'h00;
  localparam logic [6:0]        IND_PORT_LOW  = 7'h00;

  // ==========================================================================
  // register selection
  typedef enum logic [3:0] {
    SEL_NONE,
    SEL_INDIRECT,
    SEL_OPTION,
    SEL_PC_LOW,
    SEL_STATUS,
    SEL_POINTER,
    SEL_PORTB_DIR,
    SEL_PCH_LATCH,
    SEL_INT_CTRL
  } sfr_sel_e;

  function automatic sfr_sel_e sfr_select(input logic [ADDR_W-1:0] addr);
    case (addr)
      OFS_INDIRECT_PORT: sfr_select = SEL_INDIRECT;
      OFS_OPTION:        sfr_select = SEL_OPTION;
      OFS_PC_LOW:        sfr_select = SEL_PC_LOW;
      OFS_STATUS:        sfr_select = SEL_STATUS;
      OFS_IND_POINTER:   sfr_select = SEL_POINTER;
      OFS_PORTB_DIR:     sfr_select = SEL_PORTB_DIR;
      OFS_PCH_LATCH:     sfr_select = SEL_PCH_LATCH;
      OFS_INT_CONTROL:   sfr_select = SEL_INT_CTRL;
      default:           sfr_select = SEL_NONE;
    endcase
  endfunction

  function automatic logic [NBANK-1:0] bank_onehot(input logic [1:0] bank);
    bank_onehot = NBANK'(1) << bank;
  endfunction

endpackage

/* logic/sfr_addr_decode.sv */
// address decode for the bank 3 map and the indirect address path
// assumes the status bank bits and the pointer come from registers in the parent
`timescale 1ns/10ps
`default_nettype none
module sfr_addr_decode
  import sfr_pkg::*;
(
  input  wire logic [ADDR_W-1:0] addr_in,
  input  wire logic [2:0]        bank_bits_in,
  input  wire logic [DATA_W-1:0] pointer_in,
  output sfr_sel_e               sel_out,
  output logic [ADDR_W-1:0]      ind_addr_out,
  output logic                   ind_null_out,
  output logic [NBANK-1:0]       direct_bank_out
);

  // ==========================================================================
  // decode
  assign sel_out         = sfr_select(addr_in);
  assign ind_addr_out    = {bank_bits_in[2], pointer_in};
  assign ind_null_out    = (pointer_in[6:0] == IND_PORT_LOW);
  assign direct_bank_out = bank_onehot(bank_bits_in[1:0]);

endmodule
`default_nettype wire

/* logic/status_flag_unit.sv */
// arithmetic, reset-cause and bank-select status register
// assumes write and instruction strobes are already qualified by the clock enable
`timescale 1ns/10ps
`default_nettype none
module status_flag_unit
  import sfr_pkg::*;
(
  input  wire logic              clk_in,
  input  wire logic              rst_in,
  input  wire logic              wr_in,
  input  wire logic [DATA_W-1:0] wdata_in,
  input  wire logic [2:0]        flag_we_in,
  input  wire logic              flag_upd_in,
  input  wire logic              zero_in,
  input  wire logic              nibble_in,
  input  wire logic              carry_in,
  input  wire logic              sub_in,
  input  wire logic              clr_instr_in,
  input  wire logic              wdt_timeout_in,
  input  wire logic              wdt_clear_in,
  input  wire logic              sleep_in,
  output logic [DATA_W-1:0]      status_out
);

  logic [2:0] bank_reg;
  logic [2:0] flags_reg;
  logic [2:0] flags_next;
  logic [2:0] alu_flags;
  logic       wdt_exp_reg;
  logic       sleep_reg;

  // ==========================================================================
  // bank select bits
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      bank_reg <= RST_BANK_SEL;
    end else if (wr_in && clr_instr_in) begin
      bank_reg <= CLR_BANK_SEL;
    end else if (wr_in) begin
      bank_reg <= wdata_in[BIT_IND_BANK:BIT_BANK_LO];
    end
  end

  // ==========================================================================
  // alu flags
  assign alu_flags[FLG_ZERO]   = zero_in;
  assign alu_flags[FLG_NIBBLE] = sub_in ? ~nibble_in : nibble_in;
  assign alu_flags[FLG_CARRY]  = sub_in ? ~carry_in : carry_in;

  always_comb begin
    flags_next = flags_reg;
    if (wr_in && clr_instr_in) begin
      flags_next[FLG_ZERO] = 1'b1;
    end else if (wr_in && !(flag_upd_in && (flag_we_in != 3'h0))) begin
      flags_next = wdata_in[BIT_ZERO:BIT_CARRY];
    end
    if (flag_upd_in) begin
      for (int i = 0; i < 3; i++) begin
        if (flag_we_in[i]) begin
          flags_next[i] = alu_flags[i];
        end
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      flags_reg <= RST_ALU_FLAGS;
    end else begin
      flags_next_apply: flags_reg <= flags_next;
    end
  end

  // ==========================================================================
  // reset-cause bits, changed by reset, timeout and the clear and sleep instructions, never by register writes
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      wdt_exp_reg <= 1'b1;
      sleep_reg   <= 1'b1;
    end else if (wdt_timeout_in) begin
      wdt_exp_reg <= 1'b0;
    end else if (wdt_clear_in) begin
      wdt_exp_reg <= 1'b1;
      sleep_reg   <= 1'b1;
    end else if (sleep_in) begin
      wdt_exp_reg <= 1'b1;
      sleep_reg   <= 1'b0;
    end
  end

  assign status_out = {bank_reg, wdt_exp_reg, sleep_reg, flags_reg};

endmodule
`default_nettype wire

/* logic/sfr_bank3.sv */
// bank 3 special-function registers as seen by the core data path
// assumes a combinational data memory read on MEM_RDATA_IN and one core clock
// ==========================================================================
`timescale 1ns/10ps
`default_nettype none
module sfr_bank3
  import sfr_pkg::*;
#(
  parameter int DATA_WIDTH = DATA_W,
  parameter int ADDR_WIDTH = ADDR_W
)(
  input  wire logic              CORE_CLK_IN,
  input  wire logic              SYS_RST_IN,
  input  wire logic              CLK_EN_IN,
  input  wire logic [ADDR_W-1:0] ADDR_IN,
  input  wire logic              RD_IN,
  input  wire logic              WR_IN,
  input  wire logic [DATA_W-1:0] WDATA_IN,
  output logic [DATA_W-1:0]      RDATA_OUT,
  input  wire logic              FLAG_UPD_IN,
  input  wire logic [2:0]        FLAG_WE_IN,
  input  wire logic              ALU_ZERO_IN,
  input  wire logic              ALU_NIBBLE_IN,
  input  wire logic              ALU_CARRY_IN,
  input  wire logic              ALU_SUB_IN,
  input  wire logic              REG_ZERO_INSTR_IN,
  input  wire logic              WDT_TIMEOUT_IN,
  input  wire logic              WDT_CLEAR_INSTR_IN,
  input  wire logic              SLEEP_INSTR_IN,
  input  wire logic              PC_LOW_LOAD_IN,
  input  wire logic [DATA_W-1:0] PC_LOW_IN,
  output logic [ADDR_W-1:0]      MEM_ADDR_OUT,
  output logic                   MEM_RD_OUT,
  output logic                   MEM_WR_OUT,
  output logic [DATA_W-1:0]      MEM_WDATA_OUT,
  input  wire logic [DATA_W-1:0] MEM_RDATA_IN,
  output logic [DATA_W-1:0]      STATUS_OUT,
  output logic [NBANK-1:0]       DIRECT_BANK_SEL_OUT,
  output logic                   INDIRECT_BANK_OUT,
  output logic [DATA_W-1:0]      OPTION_OUT,
  output logic [DATA_W-1:0]      PC_LOW_OUT,
  output logic [PCH_W-1:0]       PCH_LATCH_OUT,
  output logic [DATA_W-1:0]      PORTB_DIR_OUT,
  output logic [DATA_W-1:0]      INT_CTRL_OUT
);

  // ==========================================================================
  // elaboration checks
  if (DATA_WIDTH != DATA_W) begin : g_bad_data
    $error("data width must be 8");
  end
  if (ADDR_WIDTH != ADDR_W) begin : g_bad_addr
    $error("address width must be 9");
  end

  // ==========================================================================
  // declarations
  sfr_sel_e            sel;
  logic [ADDR_W-1:0]   ind_addr;
  logic                ind_null;
  logic [DATA_W-1:0]   status;
  logic                wr_en;
  logic                rd_en;
  logic [DATA_W-1:0]   option_reg;
  logic [DATA_W-1:0]   pc_low_reg;
  logic [DATA_W-1:0]   pointer_reg;
  logic [DATA_W-1:0]   portb_dir_reg;
  logic [PCH_W-1:0]    pch_latch_reg;
  logic [DATA_W-1:0]   int_ctrl_reg;
  logic [DATA_W-1:0]   rdata_reg;
  logic [DATA_W-1:0]   rdata_next;

  assign wr_en = CLK_EN_IN && WR_IN;
  assign rd_en = CLK_EN_IN && RD_IN;

  // ==========================================================================
  // address decode
  sfr_addr_decode u_decode (
    .addr_in         (ADDR_IN),
    .bank_bits_in    (status[BIT_IND_BANK:BIT_BANK_LO]),
    .pointer_in      (pointer_reg),
    .sel_out         (sel),
    .ind_addr_out    (ind_addr),
    .ind_null_out    (ind_null),
    .direct_bank_out (DIRECT_BANK_SEL_OUT)
  );

  // ==========================================================================
  // status register
  status_flag_unit u_status (
    .clk_in         (CORE_CLK_IN),
    .rst_in         (SYS_RST_IN),
    .wr_in          (wr_en && (sel == SEL_STATUS)),
    .wdata_in       (WDATA_IN),
    .flag_we_in     (FLAG_WE_IN),
    .flag_upd_in    (CLK_EN_IN && FLAG_UPD_IN),
    .zero_in        (ALU_ZERO_IN),
    .nibble_in      (ALU_NIBBLE_IN),
    .carry_in       (ALU_CARRY_IN),
    .sub_in         (ALU_SUB_IN),
    .clr_instr_in   (REG_ZERO_INSTR_IN),
    .wdt_timeout_in (CLK_EN_IN && WDT_TIMEOUT_IN),
    .wdt_clear_in   (CLK_EN_IN && WDT_CLEAR_INSTR_IN),
    .sleep_in       (CLK_EN_IN && SLEEP_INSTR_IN),
    .status_out     (status)
  );

  assign STATUS_OUT        = status;
  assign INDIRECT_BANK_OUT = status[BIT_IND_BANK];

  // ==========================================================================
  // indirect access path
  assign MEM_ADDR_OUT  = ind_addr;
  assign MEM_WDATA_OUT = WDATA_IN;
  assign MEM_RD_OUT    = rd_en && (sel == SEL_INDIRECT) && !ind_null;
  assign MEM_WR_OUT    = wr_en && (sel == SEL_INDIRECT) && !ind_null;

  // ==========================================================================
  // plain storage registers
  always_ff @(posedge CORE_CLK_IN) begin
    if (SYS_RST_IN) begin
      option_reg <= RST_OPTION;
    end else if (wr_en && (sel == SEL_OPTION)) begin
      option_reg <= WDATA_IN;
    end
  end

  always_ff @(posedge CORE_CLK_IN) begin
    if (SYS_RST_IN) begin
      pc_low_reg <= RST_PC_LOW;
    end else if (wr_en && (sel == SEL_PC_LOW)) begin
      pc_low_reg <= WDATA_IN;
    end else if (CLK_EN_IN && PC_LOW_LOAD_IN) begin
      pc_low_reg <= PC_LOW_IN;
    end
  end

  always_ff @(posedge CORE_CLK_IN) begin
    if (SYS_RST_IN) begin
      pointer_reg <= RST_POINTER;
    end else if (wr_en && (sel == SEL_POINTER)) begin
      pointer_reg <= WDATA_IN;
    end
  end

  always_ff @(posedge CORE_CLK_IN) begin
    if (SYS_RST_IN) begin
      portb_dir_reg <= RST_PORTB_DIR;
    end else if (wr_en && (sel == SEL_PORTB_DIR)) begin
      portb_dir_reg <= WDATA_IN;
    end
  end

  always_ff @(posedge CORE_CLK_IN) begin
    if (SYS_RST_IN) begin
      pch_latch_reg <= RST_PCH_LATCH;
    end else if (wr_en && (sel == SEL_PCH_LATCH)) begin
      pch_latch_reg <= WDATA_IN[PCH_W-1:0];
    end
  end

  always_ff @(posedge CORE_CLK_IN) begin
    if (SYS_RST_IN) begin
      int_ctrl_reg <= RST_INT_CTRL;
    end else if (wr_en && (sel == SEL_INT_CTRL)) begin
      int_ctrl_reg <= WDATA_IN;
    end
  end

  assign OPTION_OUT    = option_reg;
  assign PC_LOW_OUT    = pc_low_reg;
  assign PCH_LATCH_OUT = pch_latch_reg;
  assign PORTB_DIR_OUT = portb_dir_reg;
  assign INT_CTRL_OUT  = int_ctrl_reg;

  // ==========================================================================
  // read path
  always_comb begin
    case (sel)
      SEL_INDIRECT:  rdata_next = ind_null ? ZERO_BYTE : MEM_RDATA_IN;
      SEL_OPTION:    rdata_next = option_reg;
      SEL_PC_LOW:    rdata_next = pc_low_reg;
      SEL_STATUS:    rdata_next = status;
      SEL_POINTER:   rdata_next = pointer_reg;
      SEL_PORTB_DIR: rdata_next = portb_dir_reg;
      SEL_PCH_LATCH: rdata_next = {{(DATA_W-PCH_W){1'b0}}, pch_latch_reg};
      SEL_INT_CTRL:  rdata_next = int_ctrl_reg;
      default:       rdata_next = ZERO_BYTE;
    endcase
  end

  always_ff @(posedge CORE_CLK_IN) begin
    if (SYS_RST_IN) begin
      rdata_reg <= ZERO_BYTE;
    end else if (rd_en) begin
      rdata_reg <= rdata_next;
    end
  end

  assign RDATA_OUT = rdata_reg;

  // ==========================================================================
  // assertions
  a_status_bank_write: assert property (
    @(posedge CORE_CLK_IN) disable iff (SYS_RST_IN)
    wr_en && (sel == SEL_STATUS) && !REG_ZERO_INSTR_IN
    |=> STATUS_OUT[BIT_IND_BANK:BIT_BANK_LO] == $past(WDATA_IN[BIT_IND_BANK:BIT_BANK_LO]))
    else $error("status bank bits not written");

  a_flag_write_block: assert property (
    @(posedge CORE_CLK_IN) disable iff (SYS_RST_IN)
    wr_en && (sel == SEL_STATUS) && !REG_ZERO_INSTR_IN && FLAG_UPD_IN
    && FLAG_WE_IN[FLG_ZERO] && !FLAG_WE_IN[FLG_CARRY]
    |=> (STATUS_OUT[BIT_ZERO] == $past(ALU_ZERO_IN))
    && (STATUS_OUT[BIT_CARRY] == $past(STATUS_OUT[BIT_CARRY])))
    else $error("status flag write not blocked");

  a_reset_cause_ro: assert property (
    @(posedge CORE_CLK_IN) disable iff (SYS_RST_IN)
    wr_en && (sel == SEL_STATUS) && !WDT_TIMEOUT_IN && !WDT_CLEAR_INSTR_IN && !SLEEP_INSTR_IN
    |=> $stable(STATUS_OUT[BIT_WDT_EXP:BIT_SLEEP]))
    else $error("reset cause bits changed by a write");

  a_clear_status: assert property (
    @(posedge CORE_CLK_IN) disable iff (SYS_RST_IN)
    wr_en && (sel == SEL_STATUS) && REG_ZERO_INSTR_IN
    && !(FLAG_UPD_IN && (FLAG_WE_IN[FLG_NIBBLE] || FLAG_WE_IN[FLG_CARRY]))
    |=> (STATUS_OUT[BIT_IND_BANK:BIT_BANK_LO] == CLR_BANK_SEL) && STATUS_OUT[BIT_ZERO]
    && $stable(STATUS_OUT[BIT_NIBBLE:BIT_CARRY]))
    else $error("status clear result wrong");

  a_borrow_polarity: assert property (
    @(posedge CORE_CLK_IN) disable iff (SYS_RST_IN)
    CLK_EN_IN && FLAG_UPD_IN && ALU_SUB_IN && FLAG_WE_IN[FLG_CARRY] && FLAG_WE_IN[FLG_NIBBLE]
    |=> (STATUS_OUT[BIT_CARRY] != $past(ALU_CARRY_IN))
    && (STATUS_OUT[BIT_NIBBLE] != $past(ALU_NIBBLE_IN)))
    else $error("borrow polarity wrong");

  a_unimpl_zero: assert property (
    @(posedge CORE_CLK_IN) disable iff (SYS_RST_IN)
    rd_en && (sel == SEL_NONE) |=> RDATA_OUT == ZERO_BYTE)
    else $error("unimplemented location not zero");

  a_status_readback: assert property (
    @(posedge CORE_CLK_IN) disable iff (SYS_RST_IN)
    rd_en && (sel == SEL_STATUS) |=> RDATA_OUT == $past(STATUS_OUT))
    else $error("status read mismatch");

  a_bank_decode: assert property (
    @(posedge CORE_CLK_IN) disable iff (SYS_RST_IN)
    (DIRECT_BANK_SEL_OUT == bank_onehot(STATUS_OUT[BIT_BANK_HI:BIT_BANK_LO]))
    && (MEM_ADDR_OUT[ADDR_W-1] == STATUS_OUT[BIT_IND_BANK]))
    else $error("bank decode wrong");

  a_wdt_sleep_flags: assert property (
    @(posedge CORE_CLK_IN) disable iff (SYS_RST_IN)
    CLK_EN_IN && SLEEP_INSTR_IN && !WDT_TIMEOUT_IN && !WDT_CLEAR_INSTR_IN
    |=> STATUS_OUT[BIT_WDT_EXP] && !STATUS_OUT[BIT_SLEEP] ##1 1'b1)
    else $error("sleep did not update flags");

  a_wdt_timeout: assert property (
    @(posedge CORE_CLK_IN) disable iff (SYS_RST_IN)
    CLK_EN_IN && WDT_TIMEOUT_IN |=> !STATUS_OUT[BIT_WDT_EXP])
    else $error("timeout did not clear expiry flag");

  a_indirect_read: assert property (
    @(posedge CORE_CLK_IN) disable iff (SYS_RST_IN)
    rd_en && (sel == SEL_INDIRECT) && !ind_null
    |-> MEM_RD_OUT ##1 (RDATA_OUT == $past(MEM_RDATA_IN)))
    else $error("indirect read not redirected");

  a_indirect_write: assert property (
    @(posedge CORE_CLK_IN) disable iff (SYS_RST_IN)
    wr_en && (sel == SEL_INDIRECT) && !ind_null
    |-> MEM_WR_OUT && (MEM_WDATA_OUT == WDATA_IN)
    && (MEM_ADDR_OUT == {STATUS_OUT[BIT_IND_BANK], pointer_reg}))
    else $error("indirect write not redirected");

  a_null_pointer: assert property (
    @(posedge CORE_CLK_IN) disable iff (SYS_RST_IN)
    (sel == SEL_INDIRECT) && ind_null |-> !MEM_RD_OUT && !MEM_WR_OUT)
    else $error("null pointer reached memory");

  a_enable_freeze: assert property (
    @(posedge CORE_CLK_IN) disable iff (SYS_RST_IN)
    !CLK_EN_IN
    |=> $stable(STATUS_OUT) && $stable(OPTION_OUT) && $stable(PC_LOW_OUT) && $stable(RDATA_OUT))
    else $error("state changed while clock enable low");

endmodule
`default_nettype wire

/* verification/data_mem_model.sv */
// behavioural data memory behind the indirect access port
// assumes combinational read and a write taken at the rising clock edge
`timescale 1ns/10ps
`default_nettype none
module data_mem_model
  import sfr_pkg::*;
(
  input  wire logic              clk_in,
  input  wire logic [ADDR_W-1:0] mem_addr_in,
  input  wire logic              mem_rd_in,
  input  wire logic              mem_wr_in,
  input  wire logic [DATA_W-1:0] mem_wdata_in,
  output logic [DATA_W-1:0]      mem_rdata_out
);
  // ==========================================================================
  // storage
  logic [DATA_W-1:0] mem_reg [0:(1<<ADDR_W)-1];
  logic [DATA_W-1:0] last_reg;

  initial last_reg = 8'h00;

  always @(posedge clk_in) begin
    if (mem_wr_in) begin
      mem_reg[mem_addr_in] <= mem_wdata_in;
    end
    if (mem_rd_in) begin
      last_reg <= mem_reg[mem_addr_in];
    end
  end

  // released data lines show the inverse of the last value
  assign mem_rdata_out = mem_rd_in ? mem_reg[mem_addr_in] : ~last_reg;
endmodule
`default_nettype wire

/* verification/sfr_bank3_tb_top.sv */
// self-checking bench for the bank 3 register map
// assumes the data memory model on the indirect path and one 100 MHz clock
`timescale 1ns/10ps
`default_nettype none
module sfr_bank3_tb_top
  import sfr_pkg::*;
;
  logic              CORE_CLK_IN = 1'b0;
  logic              SYS_RST_IN  = 1'b1;
  logic              CLK_EN_IN   = 1'b1;
  logic [ADDR_W-1:0] ADDR_IN     = 9'h000;
  logic              RD_IN       = 1'b0;
  logic              WR_IN       = 1'b0;
  logic [DATA_W-1:0] WDATA_IN    = 8'h00;
  logic              FLAG_UPD_IN = 1'b0;
  logic [2:0]        FLAG_WE_IN  = 3'h0;
  logic              ALU_ZERO_IN = 1'b0;
  logic              ALU_NIBBLE_IN = 1'b0;
  logic              ALU_CARRY_IN  = 1'b0;
  logic              ALU_SUB_IN    = 1'b0;
  logic              REG_ZERO_INSTR_IN = 1'b0;
  logic              WDT_TIMEOUT_IN = 1'b0;
  logic              WDT_CLEAR_INSTR_IN = 1'b0;
  logic              SLEEP_INSTR_IN = 1'b0;
  logic              PC_LOW_LOAD_IN = 1'b0;
  logic [DATA_W-1:0] PC_LOW_IN      = 8'h00;
  logic [DATA_W-1:0] RDATA_OUT, MEM_WDATA_OUT, MEM_RDATA_IN, STATUS_OUT, OPTION_OUT;
  logic [DATA_W-1:0] PC_LOW_OUT, PORTB_DIR_OUT, INT_CTRL_OUT;
  logic [ADDR_W-1:0] MEM_ADDR_OUT;
  logic              MEM_RD_OUT, MEM_WR_OUT, INDIRECT_BANK_OUT;
  logic [PCH_W-1:0]  PCH_LATCH_OUT;
  logic [NBANK-1:0]  DIRECT_BANK_SEL_OUT;
  int                fail_count  = 0;
  int                check_count = 0;
  int                cyc_count   = 0;

  always #5 CORE_CLK_IN = ~CORE_CLK_IN;

  sfr_bank3 sfr_bank3_i (
    .CORE_CLK_IN(CORE_CLK_IN), .SYS_RST_IN(SYS_RST_IN), .CLK_EN_IN(CLK_EN_IN), .ADDR_IN(ADDR_IN),
    .RD_IN(RD_IN), .WR_IN(WR_IN), .WDATA_IN(WDATA_IN), .RDATA_OUT(RDATA_OUT), .FLAG_UPD_IN(FLAG_UPD_IN),
    .FLAG_WE_IN(FLAG_WE_IN), .ALU_ZERO_IN(ALU_ZERO_IN), .ALU_NIBBLE_IN(ALU_NIBBLE_IN),
    .ALU_CARRY_IN(ALU_CARRY_IN), .ALU_SUB_IN(ALU_SUB_IN), .REG_ZERO_INSTR_IN(REG_ZERO_INSTR_IN),
    .WDT_TIMEOUT_IN(WDT_TIMEOUT_IN), .WDT_CLEAR_INSTR_IN(WDT_CLEAR_INSTR_IN), .SLEEP_INSTR_IN(SLEEP_INSTR_IN),
    .PC_LOW_LOAD_IN(PC_LOW_LOAD_IN), .PC_LOW_IN(PC_LOW_IN),
    .MEM_ADDR_OUT(MEM_ADDR_OUT), .MEM_RD_OUT(MEM_RD_OUT),
    .MEM_WR_OUT(MEM_WR_OUT), .MEM_WDATA_OUT(MEM_WDATA_OUT), .MEM_RDATA_IN(MEM_RDATA_IN),
    .STATUS_OUT(STATUS_OUT), .DIRECT_BANK_SEL_OUT(DIRECT_BANK_SEL_OUT), .INDIRECT_BANK_OUT(INDIRECT_BANK_OUT),
    .OPTION_OUT(OPTION_OUT), .PC_LOW_OUT(PC_LOW_OUT), .PCH_LATCH_OUT(PCH_LATCH_OUT),
    .PORTB_DIR_OUT(PORTB_DIR_OUT), .INT_CTRL_OUT(INT_CTRL_OUT)
  );

  data_mem_model data_mem_model_i (
    .clk_in(CORE_CLK_IN), .mem_addr_in(MEM_ADDR_OUT), .mem_rd_in(MEM_RD_OUT), .mem_wr_in(MEM_WR_OUT),
    .mem_wdata_in(MEM_WDATA_OUT), .mem_rdata_out(MEM_RDATA_IN)
  );

  // ==========================================================================
  // tasks
  task automatic stop_test();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [8:0] exp, input logic [8:0] got);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  // one access cycle; fl = {zero instr, flag update, flag enables, z, nibble, carry, subtract}
  task automatic op(input logic [8:0] a, input logic w, input logic [7:0] d, input logic [8:0] fl);
    @(posedge CORE_CLK_IN);
    ADDR_IN <= a;
    WR_IN <= w;
    RD_IN <= ~w;
    WDATA_IN <= d;
    {REG_ZERO_INSTR_IN, FLAG_UPD_IN, FLAG_WE_IN, ALU_ZERO_IN, ALU_NIBBLE_IN, ALU_CARRY_IN, ALU_SUB_IN} <= fl;
    @(posedge CORE_CLK_IN);
    WR_IN <= 1'b0;
    RD_IN <= 1'b0;
    {REG_ZERO_INSTR_IN, FLAG_UPD_IN, FLAG_WE_IN, ALU_ZERO_IN, ALU_NIBBLE_IN, ALU_CARRY_IN, ALU_SUB_IN} <= 9'h000;
    #1;
  endtask

  task automatic rd_chk(input string what, input logic [8:0] a, input logic [7:0] exp);
    op(a, 1'b0, 8'h00, 9'h000);
    chk(what, {1'b0, exp}, {1'b0, RDATA_OUT});
  endtask

  // ==========================================================================
  // timeout
  always @(posedge CORE_CLK_IN) begin
    cyc_count++;
    if (cyc_count > 5000) begin
      fail_count++;
      stop_test();
    end
  end

  // ==========================================================================
  // main sequence
  logic [8:0] addr_list [0:6] = '{OFS_OPTION, OFS_PC_LOW, OFS_STATUS, OFS_IND_POINTER,
                                  OFS_PORTB_DIR, OFS_PCH_LATCH, OFS_INT_CONTROL};
  logic [7:0] rst_list  [0:6] = '{8'hff, 8'h00, 8'h18, 8'h00, 8'hff, 8'h00, 8'h00};

  initial begin
    repeat (16) @(posedge CORE_CLK_IN);
    SYS_RST_IN <= 1'b0;
    for (int i = 0; i < 7; i++) rd_chk("reset value", addr_list[i], rst_list[i]);
    for (int b = 0; b < 4; b++) begin
      op(OFS_STATUS, 1'b1, {b[0], b[1:0], 5'h00}, 9'h000);
      chk("status bank", {1'b0, b[0], b[1:0], 5'h18}, {1'b0, STATUS_OUT});
      chk("bank onehot", 9'(4'h1 << b), 9'(DIRECT_BANK_SEL_OUT));
      chk("indirect bank", 9'(b[0]), 9'(INDIRECT_BANK_OUT));
    end
    op(OFS_STATUS, 1'b1, 8'h00, 9'h000);
    rd_chk("status wr zeros", OFS_STATUS, 8'h18);
    op(OFS_STATUS, 1'b1, 8'h07, 9'h0f2);
    chk("status alu wins", 9'h019, {1'b0, STATUS_OUT});
    op(OFS_STATUS, 1'b1, 8'he7, 9'h0c8);
    chk("status zero only", 9'h0fd, {1'b0, STATUS_OUT});
    op(OFS_STATUS, 1'b1, 8'he1, 9'h000);
    chk("status wr", 9'h0f9, {1'b0, STATUS_OUT});
    op(OFS_STATUS, 1'b1, 8'h00, 9'h1c8);
    chk("status zeroed", 9'h01d, {1'b0, STATUS_OUT});
    op(9'h185, 1'b0, 8'h00, 9'h0b3);
    chk("sub flags a", 9'h01e, {1'b0, STATUS_OUT});
    op(9'h185, 1'b0, 8'h00, 9'h0b7);
    chk("sub flags b", 9'h01c, {1'b0, STATUS_OUT});
    @(posedge CORE_CLK_IN) SLEEP_INSTR_IN <= 1'b1;
    @(posedge CORE_CLK_IN) SLEEP_INSTR_IN <= 1'b0;
    #1 chk("after sleep", 9'h014, {1'b0, STATUS_OUT});
    @(posedge CORE_CLK_IN) WDT_TIMEOUT_IN <= 1'b1;
    @(posedge CORE_CLK_IN) WDT_TIMEOUT_IN <= 1'b0;
    #1 chk("after timeout", 9'h004, {1'b0, STATUS_OUT});
    @(posedge CORE_CLK_IN) WDT_CLEAR_INSTR_IN <= 1'b1;
    @(posedge CORE_CLK_IN) WDT_CLEAR_INSTR_IN <= 1'b0;
    #1 chk("after wdt clear", 9'h01c, {1'b0, STATUS_OUT});
    foreach (addr_list[i]) begin
      if (addr_list[i] != OFS_STATUS) op(addr_list[i], 1'b1, 8'ha5, 9'h000);
    end
    for (int a = 9'h185; a < 9'h1a0; a++) begin
      if (a == 9'h185 || a == 9'h187 || a > 9'h18b) begin
        op(9'(a), 1'b1, 8'hff, 9'h000);
        rd_chk("unimplemented", 9'(a), 8'h00);
      end
    end
    rd_chk("option", OFS_OPTION, 8'ha5);
    rd_chk("pcl", OFS_PC_LOW, 8'ha5);
    rd_chk("portb dir", OFS_PORTB_DIR, 8'ha5);
    rd_chk("int ctrl", OFS_INT_CONTROL, 8'ha5);
    rd_chk("pch upper bits", OFS_PCH_LATCH, 8'h05);
    chk("option out", 9'h0a5, {1'b0, OPTION_OUT});
    chk("pcl out", 9'h0a5, {1'b0, PC_LOW_OUT});
    chk("pch out", 9'h005, 9'(PCH_LATCH_OUT));
    chk("portb dir out", 9'h0a5, {1'b0, PORTB_DIR_OUT});
    chk("int ctrl out", 9'h0a5, {1'b0, INT_CTRL_OUT});
    @(posedge CORE_CLK_IN) {PC_LOW_LOAD_IN, PC_LOW_IN} <= {1'b1, 8'h3c};
    @(posedge CORE_CLK_IN) PC_LOW_LOAD_IN <= 1'b0;
    #1 chk("pcl load", 9'h03c, {1'b0, PC_LOW_OUT});
    @(posedge CORE_CLK_IN) CLK_EN_IN <= 1'b0;
    op(OFS_OPTION, 1'b1, 8'h3c, 9'h000);
    @(posedge CORE_CLK_IN) CLK_EN_IN <= 1'b1;
    rd_chk("frozen option", OFS_OPTION, 8'ha5);
    op(OFS_IND_POINTER, 1'b1, 8'h45, 9'h000);
    chk("indirect addr", 9'h045, MEM_ADDR_OUT);
    op(OFS_INDIRECT_PORT, 1'b1, 8'h5a, 9'h000);
    rd_chk("indirect read", OFS_INDIRECT_PORT, 8'h5a);
    rd_chk("pointer kept", OFS_IND_POINTER, 8'h45);
    op(OFS_IND_POINTER, 1'b1, 8'h80, 9'h000);
    rd_chk("null pointer", OFS_INDIRECT_PORT, 8'h00);
    stop_test();
  end
endmodule
`default_nettype wire
